//--- hw/system_clock_config_cfg.svh
`ifndef SYSTEM_CLOCK_CONFIG_CFG_SVH
`define SYSTEM_CLOCK_CONFIG_CFG_SVH

// System clock rate and derived timing
`define CLK_PERIOD_NS     25
`define OSC_STOP_NS       2000
`define OSC_STOP_CYCLES   ((`OSC_STOP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OSC_STOP_W        8

// Divider ranges, in whole steps
`define SYSDIV_MAX        64
`define SYSDIV_SMALL_MAX  16
`define DSDIV_MAX         64

// Crystal list
`define XTAL_COUNT        27
`define XTAL_KHZ_W        15
`define XTAL_PLL_MIN_KHZ  5000

// Synchronised pin positions
`define PIN_MAIN          0
`define PIN_INT           1
`define PIN_30K           2
`define PIN_EXT32         3
`define PIN_PLL           4
`define PIN_LOCK          5
`define PIN_COUNT         6

// Sticky flag positions
`define FLAG_PLL_LOCK     0
`define FLAG_PLL_FAIL     1
`define FLAG_MAIN_STOP    2
`define FLAG_INT_STOP     3
`define FLAG_COUNT        4

// Reset values and master clock divider width
`define RESET_DIV_HALVES  8'h02
`define MCLK_DIV_W        8

`endif

//--- hw/system_clock_config_pkg.sv
package system_clock_config_pkg;

    // Run-mode oscillator choice
    typedef enum logic [2:0] {
        source_main_oscillator,
        source_internal_oscillator,
        source_internal_div4,
        source_internal_30k,
        source_external_32k
    } osc_source_t;

    // Deep-sleep oscillator choice
    typedef enum logic [1:0] {
        ds_main,
        ds_internal,
        ds_30k,
        ds_ext32
    } ds_source_t;

    // Source actually feeding the system divider
    typedef enum logic [2:0] {
        cs_main,
        cs_int,
        cs_int4,
        cs_30k,
        cs_ext32,
        cs_pll
    } clk_src_t;

endpackage

//--- hw/system_clock_config_unit.sv
`timescale 1ns/100ps
`default_nettype none
`include "system_clock_config_cfg.svh"
// Summary of operation
// - System clock is the selected source divided by an integer from 1 to 64.
// - Small variant rejects run-mode settings above divide-by-16; a half step still gives 16.5, and the deep-sleep divider is not capped.
// - Newer variants also accept half-step divider settings.
// - One select bit picks PLL output or the oscillator directly.
// - Crystal setting picks one of a fixed list from 1 to 25 MHz.
// - Five oscillator sources: main, internal, internal/4, 30 kHz, external 32 kHz.
// - External 32 kHz only with hibernation block present and enabled.
// - Separate disables stop the internal and the main oscillator.
// - A disable aimed at the oscillator clocking the system is ignored.
// - With PLL selected, lock raises a flag that software polls.
// - Separate deep-sleep divider 1 to 64 and deep-sleep source.
// - Deep-sleep option stops the precision oscillator unless still needed.
// - Deep sleep with gating keeps clocks only for deep-sleep-enabled peripherals.
// - Each GPIO port goes over AHB or APB by its own select bit.
// - I2S master clock comes from a programmable divider; zero turns it off.
// - Flags also rise on PLL failure and main or internal oscillator stop.
module system_clock_config_unit
    import system_clock_config_pkg::*;
#(
    parameter int SMALL_VARIANT = 0,                         // Run-mode divider capped at 16, plus any half step
    parameter int HALF_STEPS    = 1,                         // Half-step dividers present
    parameter int HAS_HIBERNATE = 1,                         // Hibernation block present
    parameter int PLL_MIN_KHZ   = `XTAL_PLL_MIN_KHZ,         // Lowest crystal for PLL
    parameter int NPERIPH       = 8,                         // Gated peripherals
    parameter int NGPIO         = 7                          // Selectable GPIO ports
) (
    input  wire logic                                clk,                       // 40 MHz clock
    input  wire logic                                resetn,                    // Async reset, low
    input  wire logic                                clk_en,                    // Freezes all state
    input  wire logic                                osc_main_in,               // Main oscillator pin
    input  wire logic                                osc_int_in,                // Internal oscillator
    input  wire logic                                osc_30k_in,                // 30 kHz oscillator
    input  wire logic                                osc_ext32_in,              // External 32 kHz
    input  wire logic                                pll_out_in,                // PLL output
    input  wire logic                                pll_lock_in,               // PLL lock level
    input  wire logic [5:0]                          system_divider_setting,    // Divisor minus one
    input  wire logic                                system_divider_half,       // Adds one half
    input  wire logic                                clock_bypass_pll,          // High: oscillator direct
    input  wire logic [4:0]                          crystal_frequency_setting, // Crystal list index
    input  wire system_clock_config_pkg::osc_source_t source_select,            // Run-mode source
    input  wire logic                                hibernate_enabled,         // Hibernation block on
    input  wire logic                                internal_osc_disable,      // Stop internal osc
    input  wire logic                                main_osc_disable,          // Stop main osc
    input  wire logic                                deep_sleep,                // Deep sleep active
    input  wire logic [5:0]                          deep_sleep_divider,        // Divisor minus one
    input  wire system_clock_config_pkg::ds_source_t deep_sleep_source,         // Deep-sleep source
    input  wire logic                                deep_sleep_precise_osc_off,// Power down in sleep
    input  wire logic                                clock_gating_enable,       // Auto gating on
    input  wire logic [NPERIPH-1:0]                  periph_deep_sleep_enable,  // Keep clock in sleep
    input  wire logic [NGPIO-1:0]                    gpio_ahb_select,           // High: AHB path
    input  wire logic [`MCLK_DIV_W-1:0]              mclk_divider,              // Zero turns off
    input  wire logic [`FLAG_COUNT-1:0]              flag_clear,                // Clear pulses
    output logic                                     sys_clk_out,               // Divided system clock
    output logic [7:0]                               active_divisor_halves,     // Divisor times two
    output logic                                     setting_rejected,          // Request not usable
    output logic [`XTAL_KHZ_W-1:0]                   crystal_khz,               // Declared crystal
    output logic                                     xtal_below_pll_min,        // Crystal too slow
    output logic                                     main_osc_run,              // Main osc powered
    output logic                                     int_osc_run,               // Internal osc powered
    output logic [NPERIPH-1:0]                       periph_clk_enable,         // Peripheral clocks
    output logic [NGPIO-1:0]                         gpio_on_ahb,               // Port bus path
    output logic                                     mclk_out,                  // I2S master clock
    output logic [`FLAG_COUNT-1:0]                   flags                      // Sticky events
);
    import system_clock_config_pkg::*;

    initial begin
        if (SMALL_VARIANT < 0 || SMALL_VARIANT > 1 || HALF_STEPS < 0 || HALF_STEPS > 1)
            $error("variant switches must be 0 or 1");
        if (NPERIPH < 1 || NGPIO < 1 || PLL_MIN_KHZ < 1 || PLL_MIN_KHZ > 25000)
            $error("unsupported size parameter");
        if (`OSC_STOP_CYCLES >= (1 << `OSC_STOP_W))
            $error("stop timeout does not fit its counter");
    end

    // Crystal list in kHz, figures as printed
    function automatic logic [`XTAL_KHZ_W-1:0] xtal_khz(input logic [4:0] idx);
        case (idx)
            5'h00: xtal_khz = 15'h03e8;   5'h01: xtal_khz = 15'h0730;   5'h02: xtal_khz = 15'h07d0;
            5'h03: xtal_khz = 15'h0992;   5'h04: xtal_khz = 15'h0df2;   5'h05: xtal_khz = 15'h0e60;
            5'h06: xtal_khz = 15'h0fa0;   5'h07: xtal_khz = 15'h0ffa;   5'h08: xtal_khz = 15'h132e;
            5'h09: xtal_khz = 15'h1388;   5'h0a: xtal_khz = 15'h1400;   5'h0b: xtal_khz = 15'h1770;
            5'h0c: xtal_khz = 15'h17fc;   5'h0d: xtal_khz = 15'h1cca;   5'h0e: xtal_khz = 15'h1f40;
            5'h0f: xtal_khz = 15'h1ffe;   5'h10: xtal_khz = 15'h2710;   5'h11: xtal_khz = 15'h2ee0;
            5'h12: xtal_khz = 15'h2fa8;   5'h13: xtal_khz = 15'h34bc;   5'h14: xtal_khz = 15'h37dc;
            5'h15: xtal_khz = 15'h3e80;   5'h16: xtal_khz = 15'h3fac;   5'h17: xtal_khz = 15'h4650;
            5'h18: xtal_khz = 15'h4e20;   5'h19: xtal_khz = 15'h5dc0;   5'h1a: xtal_khz = 15'h61a8;
            default: xtal_khz = 15'h0000;
        endcase
    endfunction

    // Which oscillators a divider source depends on
    function automatic logic uses_main(input clk_src_t s);
        uses_main = (s == cs_main) || (s == cs_pll);
    endfunction
    function automatic logic uses_int(input clk_src_t s);
        uses_int = (s == cs_int) || (s == cs_int4);
    endfunction

    // Pin synchronisers: a change counts once stages two and three agree
    logic [`PIN_COUNT-1:0] s1_reg, s2_reg, s3_reg, st_reg, st_next, edge_ev;
    always_comb begin
        for (int i = 0; i < `PIN_COUNT; i++) begin
            edge_ev[i] = (s2_reg[i] == s3_reg[i]) && (s3_reg[i] != st_reg[i]);
            st_next[i] = edge_ev[i] ? s3_reg[i] : st_reg[i];
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            st_reg <= '0;
        end else if (clk_en) begin
            s1_reg <= {pll_lock_in, pll_out_in, osc_ext32_in, osc_30k_in, osc_int_in, osc_main_in};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            st_reg <= st_next;
        end
    end

    // System divider; every edge of a source is one half-period of it
    clk_src_t   app_src_reg, app_src_next, req_src;
    logic [7:0] app_n_reg, app_n_next, cnt_reg, cnt_next, req_n;  // 8 bits: divide-by-64 is 128 halves
    logic [1:0] q4_reg, q4_next;
    logic       out_reg, out_next, rej_reg, rej_next, ev, req_bad;
    logic [7:0] high_len;
    always_comb begin
        q4_next = edge_ev[`PIN_INT] ? q4_reg + 2'h1 : q4_reg;
        if (deep_sleep) begin
            case (deep_sleep_source)
                ds_main:     req_src = cs_main;
                ds_internal: req_src = cs_int;
                ds_30k:      req_src = cs_30k;
                default:     req_src = cs_ext32;
            endcase
            req_n   = 8'({deep_sleep_divider, 1'b0}) + 8'h02;
            req_bad = 1'b0;
        end else begin
            if (!clock_bypass_pll) req_src = cs_pll;
            else begin
                case (source_select)
                    source_main_oscillator:     req_src = cs_main;
                    source_internal_oscillator: req_src = cs_int;
                    source_internal_div4:       req_src = cs_int4;
                    source_internal_30k:        req_src = cs_30k;
                    default:                    req_src = cs_ext32;
                endcase
            end
            req_n   = 8'({system_divider_setting, 1'b0}) + 8'h02 + 8'(system_divider_half);
            req_bad = (SMALL_VARIANT == 1 && system_divider_setting >= 6'(`SYSDIV_SMALL_MAX))
                   || (system_divider_half && (HALF_STEPS == 0
                       || system_divider_setting == 6'(`SYSDIV_MAX - 1)));
        end
        if (req_src == cs_ext32 && (HAS_HIBERNATE == 0 || !hibernate_enabled))
            req_bad = 1'b1;
        case (app_src_reg)
            cs_main:  ev = edge_ev[`PIN_MAIN];
            cs_int:   ev = edge_ev[`PIN_INT];
            cs_int4:  ev = edge_ev[`PIN_INT] && (q4_reg == 2'h3);
            cs_30k:   ev = edge_ev[`PIN_30K];
            cs_ext32: ev = edge_ev[`PIN_EXT32];
            cs_pll:   ev = edge_ev[`PIN_PLL];
            default:  ev = 1'b0;
        endcase
        app_src_next = app_src_reg;
        app_n_next   = app_n_reg;
        cnt_next     = cnt_reg;
        rej_next     = req_bad;
        // New settings take effect only at a period boundary, so no pulse is cut short
        if (ev) begin
            if (cnt_reg >= app_n_reg - 8'h01) begin
                cnt_next = 8'h00;
                if (!req_bad) begin
                    app_src_next = req_src;
                    app_n_next   = req_n;
                end
            end else cnt_next = cnt_reg + 8'h01;
        end
        high_len = (app_n_next >> 1) + {7'h00, app_n_next[0]};
        // Output moves only on a source edge, so reset leaves no stray pulse
        out_next = ev ? (cnt_next < high_len) : out_reg;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            app_src_reg <= cs_int;
            app_n_reg   <= `RESET_DIV_HALVES;
            cnt_reg     <= 8'h00;
            q4_reg      <= 2'h0;
            out_reg     <= 1'b0;
            rej_reg     <= 1'b0;
        end else if (clk_en) begin
            app_src_reg <= app_src_next;
            app_n_reg   <= app_n_next;
            cnt_reg     <= cnt_next;
            q4_reg      <= q4_next;
            out_reg     <= out_next;
            rej_reg     <= rej_next;
        end
    end
    assign sys_clk_out           = out_reg;
    assign active_divisor_halves = app_n_reg;
    assign setting_rejected      = rej_reg;

    // Oscillator power, crystal, gating, bus paths
    logic                   mrun_reg, mrun_next, irun_reg, irun_next, low_reg, low_next;
    logic [`XTAL_KHZ_W-1:0] khz_reg, khz_next;
    logic [NPERIPH-1:0]     pce_reg, pce_next;
    logic [NGPIO-1:0]       ahb_reg, ahb_next;
    always_comb begin
        mrun_next = !main_osc_disable || uses_main(app_src_reg);
        irun_next = !(internal_osc_disable || (deep_sleep && deep_sleep_precise_osc_off))
                 || uses_int(app_src_reg) || uses_int(req_src);
        khz_next  = xtal_khz(crystal_frequency_setting);
        // Flag only; a slow crystal under the PLL is left to software
        low_next  = !clock_bypass_pll && (khz_next < `XTAL_KHZ_W'(PLL_MIN_KHZ));
        for (int i = 0; i < NPERIPH; i++)
            pce_next[i] = !deep_sleep || !clock_gating_enable || periph_deep_sleep_enable[i];
        ahb_next  = gpio_ahb_select;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mrun_reg <= 1'b1;
            irun_reg <= 1'b1;
            low_reg  <= 1'b0;
            khz_reg  <= '0;
            pce_reg  <= '1;
            ahb_reg  <= '0;
        end else if (clk_en) begin
            mrun_reg <= mrun_next;
            irun_reg <= irun_next;
            low_reg  <= low_next;
            khz_reg  <= khz_next;
            pce_reg  <= pce_next;
            ahb_reg  <= ahb_next;
        end
    end
    assign main_osc_run       = mrun_reg;
    assign int_osc_run        = irun_reg;
    assign crystal_khz        = khz_reg;
    assign xtal_below_pll_min = low_reg;
    assign periph_clk_enable  = pce_reg;
    assign gpio_on_ahb        = ahb_reg;

    // Sticky events; a set in the clearing cycle wins
    logic [`FLAG_COUNT-1:0] flg_reg, flg_next, flg_set;
    logic [`OSC_STOP_W-1:0] idle_reg [2], idle_next [2];
    always_comb begin
        for (int k = 0; k < 2; k++) begin
            idle_next[k] = idle_reg[k];
            if (edge_ev[k] || !(k == 0 ? mrun_reg : irun_reg)) idle_next[k] = '0;
            else if (idle_reg[k] != `OSC_STOP_W'(`OSC_STOP_CYCLES)) idle_next[k] = idle_reg[k] + 1'b1;
        end
        flg_set[`FLAG_PLL_LOCK]  = app_src_reg == cs_pll && edge_ev[`PIN_LOCK] && s3_reg[`PIN_LOCK];
        flg_set[`FLAG_PLL_FAIL]  = app_src_reg == cs_pll && edge_ev[`PIN_LOCK] && !s3_reg[`PIN_LOCK];
        flg_set[`FLAG_MAIN_STOP] = idle_next[0] == `OSC_STOP_W'(`OSC_STOP_CYCLES)
                                && idle_reg[0] != `OSC_STOP_W'(`OSC_STOP_CYCLES);
        flg_set[`FLAG_INT_STOP]  = idle_next[1] == `OSC_STOP_W'(`OSC_STOP_CYCLES)
                                && idle_reg[1] != `OSC_STOP_W'(`OSC_STOP_CYCLES);
        flg_next = (flg_reg & ~flag_clear) | flg_set;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flg_reg     <= '0;
            idle_reg[0] <= '0;
            idle_reg[1] <= '0;
        end else if (clk_en) begin
            flg_reg     <= flg_next;
            idle_reg[0] <= idle_next[0];
            idle_reg[1] <= idle_next[1];
        end
    end
    assign flags = flg_reg;

    // I2S master clock: toggles every mclk_divider cycles
    logic [`MCLK_DIV_W-1:0] mcnt_reg, mcnt_next;
    logic                   mclk_reg, mclk_next;
    always_comb begin
        mcnt_next = mcnt_reg + 1'b1;
        mclk_next = mclk_reg;
        if (mclk_divider == '0) begin
            mcnt_next = '0;
            mclk_next = 1'b0;
        end else if (mcnt_reg >= mclk_divider - 1'b1) begin
            mcnt_next = '0;
            mclk_next = !mclk_reg;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mcnt_reg <= '0;
            mclk_reg <= 1'b0;
        end else if (clk_en) begin
            mcnt_reg <= mcnt_next;
            mclk_reg <= mclk_next;
        end
    end
    assign mclk_out = mclk_reg;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_div_range;
        active_divisor_halves >= 8'h02 && active_divisor_halves <= 8'(2 * `SYSDIV_MAX);
    endproperty
    a_div_range: assert property (p_div_range) else $error("divisor out of range");
    property p_small_cap;
        SMALL_VARIANT == 0 || active_divisor_halves <= 8'(2 * `SYSDIV_SMALL_MAX);
    endproperty
    a_small_cap: assert property (p_small_cap) else $error("small variant divisor too large");
    property p_ext32_ok;
        $changed(app_src_reg) && app_src_reg == cs_ext32 |-> HAS_HIBERNATE == 1 && $past(hibernate_enabled);
    endproperty
    a_ext32_ok: assert property (p_ext32_ok) else $error("32k source without hibernation");
    property p_keep_main;
        clk_en && uses_main(app_src_reg) |=> main_osc_run;
    endproperty
    a_keep_main: assert property (p_keep_main) else $error("active main oscillator stopped");
    property p_lock_flag;
        clk_en && flg_set[`FLAG_PLL_LOCK] |=> flags[`FLAG_PLL_LOCK] [*1] ##1 (flags[`FLAG_PLL_LOCK] || $past(flag_clear[0]) || !$past(clk_en));
    endproperty
    a_lock_flag: assert property (p_lock_flag) else $error("lock flag lost");
    property p_gating;
        clk_en && deep_sleep && clock_gating_enable && !periph_deep_sleep_enable[0] |=> !periph_clk_enable[0];
    endproperty
    a_gating: assert property (p_gating) else $error("gated peripheral still clocked");
    property p_mclk_off;
        clk_en && mclk_divider == '0 |=> !mclk_out;
    endproperty
    a_mclk_off: assert property (p_mclk_off) else $error("master clock not off");
    property p_edge_only;
        $changed(sys_clk_out) |-> $past(ev) && $past(clk_en);
    endproperty
    a_edge_only: assert property (p_edge_only) else $error("system clock moved without source edge");
    property p_switch_boundary;
        $changed(app_n_reg) |-> cnt_reg == 8'h00 && sys_clk_out;
    endproperty
    a_switch_boundary: assert property (p_switch_boundary) else $error("divider changed mid period");

endmodule
`default_nettype wire

//--- dv/tb_system_clock_config_unit.sv
`timescale 1ns/100ps
`default_nettype none
module tb_system_clock_config_unit;
    import system_clock_config_pkg::*;
    // Bench-driven inputs, all defined from time zero
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        clk_en = 1'b1;
    logic        osc_main_in = 1'b0;
    logic        osc_int_in = 1'b0;
    logic        osc_30k_in = 1'b0;
    logic        osc_ext32_in = 1'b0;
    logic        pll_out_in = 1'b0;
    logic        pll_lock_in = 1'b0;
    logic [5:0]  system_divider_setting = 6'h00;
    logic        system_divider_half = 1'b0;
    logic        clock_bypass_pll = 1'b1;
    logic [4:0]  crystal_frequency_setting = 5'h1f;
    osc_source_t source_select = source_internal_oscillator;
    logic        hibernate_enabled = 1'b0;
    logic        internal_osc_disable = 1'b0;
    logic        main_osc_disable = 1'b0;
    logic        deep_sleep = 1'b0;
    logic [5:0]  deep_sleep_divider = 6'h00;
    ds_source_t  deep_sleep_source = ds_internal;
    logic        deep_sleep_precise_osc_off = 1'b0;
    logic        clock_gating_enable = 1'b0;
    logic [7:0]  periph_deep_sleep_enable = 8'h00;
    logic [6:0]  gpio_ahb_select = 7'h00;
    logic [7:0]  mclk_divider = 8'h00;
    logic [3:0]  flag_clear = 4'h0;
    // Design outputs
    logic        sys_clk_out;
    logic [7:0]  active_divisor_halves;
    logic        setting_rejected;
    logic [14:0] crystal_khz;
    logic        xtal_below_pll_min;
    logic        main_osc_run;
    logic        int_osc_run;
    logic [7:0]  periph_clk_enable;
    logic [6:0]  gpio_on_ahb;
    logic        mclk_out;
    logic [3:0]  flags;
    // Bench bookkeeping
    int          compares = 0;
    int          n_mismatch = 0;
    int          i;
    int          n;
    logic        b;
    logic        main_on = 1'b1;
    logic        int_on = 1'b1;
    logic [3:0]  tick = 4'h0;
    logic [4:0]  xi [5] = '{5'h00, 5'h08, 5'h09, 5'h1a, 5'h1b};
    logic [14:0] xk [5] = '{15'h03e8, 15'h132e, 15'h1388, 15'h61a8, 15'h0000};

    system_clock_config_unit system_clock_config_unit_i (.*);

    always #12.5 clk = ~clk;

    // Source clocks well below clk/8; main can be halted to provoke a stop event
    always @(negedge clk) begin
        tick <= (tick == 4'h9) ? 4'h0 : tick + 4'h1;
        if (tick == 4'h9) begin
            osc_int_in <= osc_int_in ^ int_on;
            pll_out_in <= ~pll_out_in;
            osc_main_in <= osc_main_in ^ main_on;
        end
    end

    task wt(input int c);
        repeat (c) @(negedge clk);
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task finish_test();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watchdog, far beyond the roughly 550 cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end

    // Main sequence
    initial begin
        wt(2);
        chk(active_divisor_halves, 7'h02);
        chk(periph_clk_enable, 8'hff);
        chk(flags, 4'h0);
        wt(2);
        resetn = 1'b1;
        for (i = 0; i < 5; i++) begin
            crystal_frequency_setting = xi[i];
            wt(2);
            chk(crystal_khz, xk[i]);
        end
        // Clock enable low freezes every register
        clk_en = 1'b0;
        crystal_frequency_setting = 5'h00;
        wt(2);
        chk(crystal_khz, 15'h0000);
        clk_en = 1'b1;
        wt(2);
        chk(crystal_khz, 15'h03e8);
        // Disable aimed at the oscillator in use must be ignored
        internal_osc_disable = 1'b1;
        main_osc_disable = 1'b1;
        wt(2);
        chk(int_osc_run, 1'b1);
        chk(main_osc_run, 1'b0);
        internal_osc_disable = 1'b0;
        main_osc_disable = 1'b0;
        gpio_ahb_select = 7'h55;
        wt(2);
        chk(gpio_on_ahb, 7'h55);
        deep_sleep = 1'b1;
        clock_gating_enable = 1'b1;
        periph_deep_sleep_enable = 8'ha5;
        deep_sleep_divider = 6'h02;
        deep_sleep_precise_osc_off = 1'b1;
        wt(2);
        chk(periph_clk_enable, 8'ha5);
        chk(int_osc_run, 1'b1);
        for (i = 0; i < 300 && active_divisor_halves !== 8'h06; i++) wt(1);
        chk(active_divisor_halves, 8'h06);
        clock_gating_enable = 1'b0;
        wt(2);
        chk(periph_clk_enable, 8'hff);
        deep_sleep = 1'b0;
        // Master clock half period and switch-off
        mclk_divider = 8'h03;
        wt(8);
        b = mclk_out;
        for (i = 0; i < 20 && mclk_out === b; i++) wt(1);
        b = mclk_out;
        for (n = 0; n < 20 && mclk_out === b; n++) wt(1);
        chk(n, 3);
        mclk_divider = 8'h00;
        wt(2);
        chk(mclk_out, 1'b0);
        // Divide by two; high phase is two source half-periods of ten cycles
        system_divider_setting = 6'h01;
        for (i = 0; i < 300 && active_divisor_halves !== 7'h04; i++) wt(1);
        chk(active_divisor_halves, 7'h04);
        for (i = 0; i < 100 && sys_clk_out !== 1'b0; i++) wt(1);
        for (i = 0; i < 100 && sys_clk_out !== 1'b1; i++) wt(1);
        for (n = 0; n < 100 && sys_clk_out === 1'b1; n++) wt(1);
        chk(n, 20);
        // Half step on top of divide-by-64 is out of range
        system_divider_setting = 6'h3f;
        system_divider_half = 1'b1;
        for (i = 0; i < 300 && setting_rejected !== 1'b1; i++) wt(1);
        chk(setting_rejected, 1'b1);
        chk(active_divisor_halves, 7'h04);
        system_divider_setting = 6'h02;
        for (i = 0; i < 300 && active_divisor_halves !== 7'h07; i++) wt(1);
        wt(2);
        chk(active_divisor_halves, 7'h07);
        chk(setting_rejected, 1'b0);
        source_select = source_external_32k;
        for (i = 0; i < 300 && setting_rejected !== 1'b1; i++) wt(1);
        chk(setting_rejected, 1'b1);
        source_select = source_internal_oscillator;
        // Move onto the PLL, then lock, unlock and main stop events
        crystal_frequency_setting = 5'h08;
        clock_bypass_pll = 1'b0;
        wt(200);
        chk(xtal_below_pll_min, 1'b1);
        crystal_frequency_setting = 5'h09;
        wt(2);
        chk(xtal_below_pll_min, 1'b0);
        pll_lock_in = 1'b1;
        wt(6);
        chk(flags[0], 1'b1);
        flag_clear = 4'h1;
        wt(1);
        flag_clear = 4'h0;
        wt(1);
        chk(flags[0], 1'b0);
        pll_lock_in = 1'b0;
        wt(6);
        chk(flags[1], 1'b1);
        main_on = 1'b0;
        int_on = 1'b0;
        wt(120);
        chk(flags[2], 1'b1);
        chk(flags[3], 1'b1);
        finish_test();
    end
endmodule
`default_nettype wire
